// file: slc_regs.vh
// slc_regs.vh: offsets, field positions, reset values and frame counts
// for the serial-lane control register slice.
// assumes: included by bare name from every design file of the slice.
`ifndef SLC_REGS_VH
`define SLC_REGS_VH

// ----------------------------------------------------------------------
// register offsets on the serial control port (15-bit address space)
// ----------------------------------------------------------------------
`define SLC_ADDR_LANE_PD 15'h0201
`define SLC_ADDR_SYNC_PD 15'h0203
`define SLC_ADDR_CDR_RST 15'h0206
`define SLC_ADDR_IND_ADDR 15'h0210
`define SLC_ADDR_COMMIT_LANES 15'h0212
`define SLC_ADDR_COMMIT_OTHER 15'h0213
`define SLC_ADDR_IND_DATA 15'h0216
`define SLC_ADDR_POLARITY 15'h0234
`define SLC_ADDR_EQ_LOW 15'h0240
`define SLC_ADDR_EQ_HIGH 15'h0241

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define SLC_BIT_SYNC_A_OFF 1
`define SLC_BIT_SYNC_B_OFF 0
`define SLC_BIT_CDR_RELEASE 0
`define SLC_BIT_COMMIT_OTHER 0
`define SLC_EQ_FIELD_W 2

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define SLC_RST_LANE_PD 8'hEE
`define SLC_RST_SYNC_A_OFF 1'h0
`define SLC_RST_SYNC_B_OFF 1'h1
`define SLC_RST_CDR_RELEASE 1'h0
`define SLC_RST_IND_ADDR 8'h00
`define SLC_RST_IND_DATA 8'h00
`define SLC_RST_COMMIT 8'h00
`define SLC_RST_POLARITY 8'h66
`define SLC_RST_EQ 8'hFF
`define SLC_RD_UNMAPPED 8'h00

// ----------------------------------------------------------------------
// serial frame: 1 direction bit, 15 address bits, 8 data bits
// ----------------------------------------------------------------------
`define SLC_FRAME_INSTR_BITS 5'h10
`define SLC_FRAME_TOTAL_BITS 5'h18
`define SLC_FRAME_RD_BIT 15

`endif

// file: slc_spi_port.v
// slc_spi_port.v: serial control port slave, one byte per frame.
// assumes: spi pins are asynchronous to clk; serial clock at most clk/10,
// mode 0, msb first.
`timescale 1ns/1ps
`default_nettype none
`include "slc_regs.vh"

module slc_spi_port (
    // clock and reset
    input wire clk,
    input wire rst_n,
    // serial pins
    input wire spiClk,
    input wire spiCsN,
    input wire spiDataIn,
    output reg spiDataOut,
    output reg spiDataOutEn,
    // register side
    output reg wrStrobe,
    output reg rdStrobe,
    output reg [14:0] regAddr,
    output reg [7:0] wrData,
    input wire [7:0] rdData
);

    reg [2:0] clkSync_reg;
    reg [1:0] csSync_reg;
    reg [2:0] dinSync_reg;
    reg [4:0] bitCount_reg;
    reg [14:0] shift_reg;
    reg readFrame_reg;
    reg loadOut_reg;
    reg [7:0] outShift_reg;

    // ------------------------------------------------------------------
    // pin synchronisers; only stage 1 onward is looked at
    // ------------------------------------------------------------------
    wire sclkRise = clkSync_reg[1] & ~clkSync_reg[2];
    wire sclkFall = ~clkSync_reg[1] & clkSync_reg[2];
    wire frameOn = ~csSync_reg[1];
    // data is delayed like the clock so both line up at the edge
    wire sampleBit = dinSync_reg[2];

    // sync chains, frame bit counter and shift logic
    always @(posedge clk) begin
        if (!rst_n) begin
            clkSync_reg <= 3'h0;
            csSync_reg <= 2'h3;
            dinSync_reg <= 3'h0;
            bitCount_reg <= 5'h00;
            shift_reg <= 15'h0000;
            readFrame_reg <= 1'b0;
            loadOut_reg <= 1'b0;
            outShift_reg <= 8'h00;
            wrStrobe <= 1'b0;
            rdStrobe <= 1'b0;
            regAddr <= 15'h0000;
            wrData <= 8'h00;
            spiDataOut <= 1'b0;
            spiDataOutEn <= 1'b0;
        end else begin
            clkSync_reg <= {clkSync_reg[1:0], spiClk};
            csSync_reg <= {csSync_reg[0], spiCsN};
            dinSync_reg <= {dinSync_reg[1:0], spiDataIn};
            wrStrobe <= 1'b0;
            rdStrobe <= 1'b0;
            loadOut_reg <= rdStrobe;
            if (!frameOn) begin
                // frame end drops any partial byte
                bitCount_reg <= 5'h00;
                readFrame_reg <= 1'b0;
            end else if (sclkRise && bitCount_reg != `SLC_FRAME_TOTAL_BITS) begin
                bitCount_reg <= bitCount_reg + 5'h01;
                shift_reg <= {shift_reg[13:0], sampleBit};
                if (bitCount_reg == 5'h00) begin
                    readFrame_reg <= sampleBit;
                end
                if (bitCount_reg == `SLC_FRAME_INSTR_BITS - 5'h01) begin
                    regAddr <= {shift_reg[13:0], sampleBit};
                    rdStrobe <= readFrame_reg;
                end
                if (bitCount_reg == `SLC_FRAME_TOTAL_BITS - 5'h01 && !readFrame_reg) begin
                    wrData <= {shift_reg[6:0], sampleBit};
                    wrStrobe <= 1'b1;
                end
            end
            // read byte out msb first, shifted on each fall after the seventeenth rise
            if (loadOut_reg) begin
                outShift_reg <= rdData;
            end else if (sclkFall && bitCount_reg > `SLC_FRAME_INSTR_BITS) begin
                outShift_reg <= {outShift_reg[6:0], 1'b0};
            end
            spiDataOut <= outShift_reg[7];
            spiDataOutEn <= frameOn & readFrame_reg & (bitCount_reg >= `SLC_FRAME_INSTR_BITS);
        end
    end

endmodule // slc_spi_port
`default_nettype wire

// file: slc_commit_gen.v
// slc_commit_gen.v: turns a write to a commit strobe register into a
// one-cycle config write with the held address and data.
// assumes: strobe inputs are one-cycle pulses on clk.
`timescale 1ns/1ps
`default_nettype none
`include "slc_regs.vh"

module slc_commit_gen (
    // clock and reset
    input wire clk,
    input wire rst_n,
    // strobe writes
    input wire commitLanesWr,
    input wire [7:0] commitLanesVal,
    input wire commitOtherWr,
    input wire commitOtherVal,
    // staged configuration
    input wire [7:0] stagedAddr,
    input wire [7:0] stagedData,
    // configuration bus
    output reg [7:0] cfgWriteLanes,
    output reg cfgWriteOther,
    output reg [7:0] cfgAddr,
    output reg [7:0] cfgData
);

    // ------------------------------------------------------------------
    // snapshot on commit so later staging writes cannot disturb it
    // ------------------------------------------------------------------
    always @(posedge clk) begin
        if (!rst_n) begin
            cfgWriteLanes <= 8'h00;
            cfgWriteOther <= 1'b0;
            cfgAddr <= 8'h00;
            cfgData <= 8'h00;
        end else begin
            cfgWriteLanes <= commitLanesWr ? commitLanesVal : 8'h00; // R08
            cfgWriteOther <= commitOtherWr & commitOtherVal; // R08
            if (commitLanesWr || commitOtherWr) begin
                cfgAddr <= stagedAddr; // R09
                cfgData <= stagedData; // R09
            end
        end
    end

endmodule // slc_commit_gen
`default_nettype wire

// file: slc_lane_ctrl.v
// slc_lane_ctrl.v: serial-lane control register slice, top module.
// assumes: host reaches it over a 4-wire serial control port; lane
// receivers, sync drivers and the lane config bus sit outside.
//
// Overview of operation
// R01: eight-bit lane power-down override, bit n for lane n, resets to 0xEE.
// R02: a one powers lane n receiver down, a zero leaves it active.
// R03: bit 1 of sync power-down turns driver A off; resets to zero.
// R04: bit 0 of sync power-down turns driver B off; resets to one.
// R05: lanes stay in reset until software writes one to release bit 0.
// R06: eight-bit indirect address register selecting lane config location, reset zero.
// R07: eight-bit indirect data register holding value to write, reset zero.
// R08: lane strobe register and one-bit other strobe; writing a one to any strobe bit of either commits.
// R09: host writes address, data, then strobe; data applied only on strobe.
// R10: two-bit equalizer boost per lane, four per register, reset 11.
// R11: eight-bit polarity mask, bit x one inverts lane x, resets 0x66.
`timescale 1ns/1ps
`default_nettype none
`include "slc_regs.vh"

module slc_lane_ctrl #(
    parameter LANES = 8
) (
    // clock and reset
    input wire clk,
    input wire rst_n,
    // serial control port
    input wire spiClk,
    input wire spiCsN,
    input wire spiDataIn,
    output wire spiDataOut,
    output wire spiDataOutEn,
    // lane receiver controls
    output reg [7:0] lanePowerdownMask,
    output reg [LANES-1:0] laneActive,
    output reg laneRecoveryResetRelease,
    output reg laneRxResetHold,
    output reg [7:0] lanePolarityMask,
    output reg [15:0] laneEqualizerBoost,
    // sync output drivers
    output reg syncDriverAOff,
    output reg syncDriverBOff,
    // indirect configuration bus
    output reg [7:0] indirectAddress,
    output reg [7:0] indirectData,
    output wire [7:0] cfgWriteLanes,
    output wire cfgWriteOther,
    output wire [7:0] cfgAddr,
    output wire [7:0] cfgData
);

    wire wrStrobe;
    wire rdStrobe;
    wire [14:0] regAddr;
    wire [7:0] wrData;
    reg [7:0] rdData;
    reg [7:0] indirectCommitLanes_reg;
    reg indirectCommitOther_reg;
    reg commitLanesWr_reg;
    reg commitOtherWr_reg;

    // ------------------------------------------------------------------
    // serial control port slave
    // ------------------------------------------------------------------
    slc_spi_port u_spi (
        .clk(clk),
        .rst_n(rst_n),
        .spiClk(spiClk),
        .spiCsN(spiCsN),
        .spiDataIn(spiDataIn),
        .spiDataOut(spiDataOut),
        .spiDataOutEn(spiDataOutEn),
        .wrStrobe(wrStrobe),
        .rdStrobe(rdStrobe),
        .regAddr(regAddr),
        .wrData(wrData),
        .rdData(rdData)
    );

    // ------------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------------
    wire hitLanePd = (regAddr == `SLC_ADDR_LANE_PD);
    wire hitSyncPd = (regAddr == `SLC_ADDR_SYNC_PD);
    wire hitCdrRst = (regAddr == `SLC_ADDR_CDR_RST);
    wire hitIndAddr = (regAddr == `SLC_ADDR_IND_ADDR);
    wire hitCommitLanes = (regAddr == `SLC_ADDR_COMMIT_LANES);
    wire hitCommitOther = (regAddr == `SLC_ADDR_COMMIT_OTHER);
    wire hitIndData = (regAddr == `SLC_ADDR_IND_DATA);
    wire hitPolarity = (regAddr == `SLC_ADDR_POLARITY);
    wire hitEqLow = (regAddr == `SLC_ADDR_EQ_LOW);
    wire hitEqHigh = (regAddr == `SLC_ADDR_EQ_HIGH);

    // ------------------------------------------------------------------
    // lane power-down override and sync driver power-down
    // ------------------------------------------------------------------
    // unmapped writes change nothing
    always @(posedge clk) begin
        if (!rst_n) begin
            lanePowerdownMask <= `SLC_RST_LANE_PD; // R01
            syncDriverAOff <= `SLC_RST_SYNC_A_OFF; // R03
            syncDriverBOff <= `SLC_RST_SYNC_B_OFF; // R04
        end else if (wrStrobe) begin
            if (hitLanePd) begin
                lanePowerdownMask <= wrData; // R01
            end
            if (hitSyncPd) begin
                syncDriverAOff <= wrData[`SLC_BIT_SYNC_A_OFF]; // R03
                syncDriverBOff <= wrData[`SLC_BIT_SYNC_B_OFF]; // R04
            end
        end
    end

    // ------------------------------------------------------------------
    // recovery reset release
    // ------------------------------------------------------------------
    // hold kept as its own flop so the lane side sees a
    // plain active-high reset with no inverter
    always @(posedge clk) begin
        if (!rst_n) begin
            laneRecoveryResetRelease <= `SLC_RST_CDR_RELEASE; // R05
            laneRxResetHold <= 1'b1; // R05
        end else if (wrStrobe && hitCdrRst) begin
            laneRecoveryResetRelease <= wrData[`SLC_BIT_CDR_RELEASE]; // R05
            laneRxResetHold <= ~wrData[`SLC_BIT_CDR_RELEASE]; // R05
        end
    end

    // ------------------------------------------------------------------
    // indirect configuration staging
    // ------------------------------------------------------------------
    // staging registers only; nothing reaches the lanes until a strobe
    always @(posedge clk) begin
        if (!rst_n) begin
            indirectAddress <= `SLC_RST_IND_ADDR; // R06
            indirectData <= `SLC_RST_IND_DATA; // R07
        end else if (wrStrobe) begin
            if (hitIndAddr) begin
                indirectAddress <= wrData; // R06
            end
            if (hitIndData) begin
                indirectData <= wrData; // R07
            end
        end
    end

    // ------------------------------------------------------------------
    // commit strobe registers
    // ------------------------------------------------------------------
    // value is kept for read-back; each write with a strobe bit set raises the commit,
    // so writing the same such value twice commits twice
    always @(posedge clk) begin
        if (!rst_n) begin
            indirectCommitLanes_reg <= `SLC_RST_COMMIT;
            indirectCommitOther_reg <= 1'b0;
            commitLanesWr_reg <= 1'b0;
            commitOtherWr_reg <= 1'b0;
        end else begin
            commitLanesWr_reg <= wrStrobe & hitCommitLanes; // R08
            commitOtherWr_reg <= wrStrobe & hitCommitOther; // R08
            if (wrStrobe && hitCommitLanes) begin
                indirectCommitLanes_reg <= wrData;
            end
            if (wrStrobe && hitCommitOther) begin
                indirectCommitOther_reg <= wrData[`SLC_BIT_COMMIT_OTHER];
            end
        end
    end

    // commit engine: snapshot of staging plus one-cycle write pulses
    slc_commit_gen u_commit (
        .clk(clk),
        .rst_n(rst_n),
        .commitLanesWr(commitLanesWr_reg),
        .commitLanesVal(indirectCommitLanes_reg),
        .commitOtherWr(commitOtherWr_reg),
        .commitOtherVal(indirectCommitOther_reg),
        .stagedAddr(indirectAddress),
        .stagedData(indirectData),
        .cfgWriteLanes(cfgWriteLanes),
        .cfgWriteOther(cfgWriteOther),
        .cfgAddr(cfgAddr),
        .cfgData(cfgData)
    );

    // ------------------------------------------------------------------
    // polarity and equalizer boost
    // ------------------------------------------------------------------
    // codes 00 and 01 are stored as written; only 10 and 11
    // are meaningful, and software picks between them
    always @(posedge clk) begin
        if (!rst_n) begin
            lanePolarityMask <= `SLC_RST_POLARITY; // R11
            laneEqualizerBoost <= {`SLC_RST_EQ, `SLC_RST_EQ}; // R10
        end else if (wrStrobe) begin
            if (hitPolarity) begin
                lanePolarityMask <= wrData; // R11
            end
            if (hitEqLow) begin
                laneEqualizerBoost[7:0] <= wrData; // R10
            end
            if (hitEqHigh) begin
                laneEqualizerBoost[15:8] <= wrData; // R10
            end
        end
    end

    // ------------------------------------------------------------------
    // per-lane receiver state
    // ------------------------------------------------------------------
    // a lane runs only when not overridden off and reset is released
    genvar lane;
    generate
        for (lane = 0; lane < LANES; lane = lane + 1) begin : g_lane
            always @(posedge clk) begin
                if (!rst_n) begin
                    laneActive[lane] <= 1'b0;
                end else begin
                    laneActive[lane] <= ~lanePowerdownMask[lane] & laneRecoveryResetRelease; // R02
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------------
    // read-back mux
    // ------------------------------------------------------------------
    // reserved bits read zero, unmapped addresses read a fixed value
    always @* begin
        rdData = `SLC_RD_UNMAPPED;
        case (1'b1)
            hitLanePd: begin
                rdData = lanePowerdownMask;
            end
            hitSyncPd: begin
                rdData = {6'h00, syncDriverAOff, syncDriverBOff};
            end
            hitCdrRst: begin
                rdData = {7'h00, laneRecoveryResetRelease};
            end
            hitIndAddr: begin
                rdData = indirectAddress;
            end
            hitCommitLanes: begin
                rdData = indirectCommitLanes_reg;
            end
            hitCommitOther: begin
                rdData = {7'h00, indirectCommitOther_reg};
            end
            hitIndData: begin
                rdData = indirectData;
            end
            hitPolarity: begin
                rdData = lanePolarityMask;
            end
            hitEqLow: begin
                rdData = laneEqualizerBoost[7:0];
            end
            hitEqHigh: begin
                rdData = laneEqualizerBoost[15:8];
            end
            default: begin
                rdData = `SLC_RD_UNMAPPED;
            end
        endcase
    end

    // rdStrobe only marks a read; the port latches rdData one cycle after it
    wire unusedRd = rdStrobe;

endmodule // slc_lane_ctrl
`default_nettype wire

// file: slc_lane_ctrl_asserts.sv
// slc_lane_ctrl_asserts.sv: port-level checker for the lane control slice.
// assumes: bound to slc_lane_ctrl; one clock, sync active-low reset.
`timescale 1ns/1ps
`default_nettype none

module slc_lane_ctrl_chk #(
    parameter LANES = 8
) (
    // clock, reset and frame select
    input wire clk,
    input wire rst_n,
    input wire spiCsN,
    input wire spiDataOutEn,
    // lane controls
    input wire [7:0] lanePowerdownMask,
    input wire [LANES-1:0] laneActive,
    input wire laneRecoveryResetRelease,
    input wire laneRxResetHold,
    input wire [7:0] lanePolarityMask,
    input wire [15:0] laneEqualizerBoost,
    input wire syncDriverAOff,
    input wire syncDriverBOff,
    // indirect configuration
    input wire [7:0] indirectAddress,
    input wire [7:0] indirectData,
    input wire [7:0] cfgWriteLanes,
    input wire cfgWriteOther,
    input wire [7:0] cfgAddr,
    input wire [7:0] cfgData
);
    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    // stored register outputs as one word
    wire [50:0] allRegs = {lanePowerdownMask, lanePolarityMask, laneEqualizerBoost,
        syncDriverAOff, syncDriverBOff, laneRecoveryResetRelease,
        indirectAddress, indirectData};
    wire [LANES-1:0] maskLanes = lanePowerdownMask[LANES-1:0];
    wire anyCommit = (|cfgWriteLanes) || cfgWriteOther;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    // ----------------------------------------------------------------
    // properties
    // ----------------------------------------------------------------
    lane_active_map_a: assert property (laneActive == (~$past(maskLanes) &
        {LANES{$past(laneRecoveryResetRelease)}})) else $error("laneActive wrong");
    rx_hold_inverse_a: assert property (laneRxResetHold != laneRecoveryResetRelease)
        else $error("lane reset hold wrong");
    lanes_pulse_once_a: assert property (|cfgWriteLanes |=> cfgWriteLanes == 8'h00)
        else $error("lane commit longer than one cycle");
    other_pulse_once_a: assert property (cfgWriteOther |=> !cfgWriteOther)
        else $error("other commit longer than one cycle");
    cfg_only_commit_a: assert property (($changed(cfgAddr) || $changed(cfgData))
        |-> anyCommit) else $error("config changed without commit");
    commit_snapshot_a: assert property (anyCommit |-> cfgAddr == indirectAddress
        && cfgData == indirectData) else $error("commit carries wrong address or data");
    regs_idle_stable_a: assert property ($rose(spiCsN) |=> $stable(allRegs) [*8])
        else $error("register changed outside a frame");
    reset_values_a: assert property ($rose(rst_n) |-> lanePowerdownMask == 8'hEE
        && !syncDriverAOff && syncDriverBOff && !laneRecoveryResetRelease
        && lanePolarityMask == 8'h66 && laneEqualizerBoost == 16'hFFFF
        && indirectAddress == 8'h00 && indirectData == 8'h00)
        else $error("reset values wrong");

    // main scenarios
    cover property ($rose(laneRecoveryResetRelease));
    cover property (|cfgWriteLanes);
    cover property (cfgWriteOther);
    cover property ($rose(spiDataOutEn));
endmodule // slc_lane_ctrl_chk

bind slc_lane_ctrl slc_lane_ctrl_chk #(.LANES(LANES)) u_slc_lane_ctrl_chk (.*);
`default_nettype wire

// file: slc_host_model.sv
// slc_host_model.sv: host side of the serial control port, mode 0, msb first.
// assumes: clk is the slice clock; serial clock runs at clk/16.
`timescale 1ns/1ps
`default_nettype none

module slc_host_model (
    // clock
    input wire clk,
    // serial pins
    output logic spiClk,
    output logic spiCsN,
    output logic spiDataIn,
    input wire spiDataOut
);
    localparam int HALF = 8; // half serial period in clk cycles
    logic [23:0] word;
    integer k;

    // serial clock stands low between frames
    initial begin
        spiClk = 1'b0;
        spiCsN = 1'b1;
        spiDataIn = 1'b0;
    end

    // nbits below 24 aborts the frame
    task frame(input rw, input [14:0] addr, input [7:0] data, input integer nbits,
        output [7:0] q);
        word = {rw, addr, data};
        q = 8'h00;
        @(posedge clk);
        spiCsN <= 1'b0;
        repeat (4) @(posedge clk);
        for (k = 23; k > 23 - nbits; k = k - 1) begin
            spiDataIn <= word[k];
            repeat (HALF) @(posedge clk);
            spiClk <= 1'b1;
            if (k < 8) q[k] = spiDataOut; // moves only after a fall or the load after the sixteenth rise
            repeat (HALF) @(posedge clk);
            spiClk <= 1'b0;
        end
        repeat (HALF) @(posedge clk);
        spiCsN <= 1'b1;
        spiDataIn <= ~spiDataIn; // released line never keeps the last bit
        repeat (HALF) @(posedge clk);
    endtask
endmodule // slc_host_model
`default_nettype wire

// file: tb_slc_lane_ctrl.sv
// tb_slc_lane_ctrl.sv: self-checking bench for the lane control slice.
// assumes: host model drives the serial port; bench mirrors every register.
`timescale 1ns/1ps
`default_nettype none
`include "slc_regs.vh"

module tb_slc_lane_ctrl;
    // ----------------------------------------------------------------
    // signals and tables
    // ----------------------------------------------------------------
    logic clk, rst_n;
    wire spiClk, spiCsN, spiDataIn, spiDataOut, spiDataOutEn;
    wire laneRecoveryResetRelease, laneRxResetHold, syncDriverAOff, syncDriverBOff, cfgWriteOther;
    wire [7:0] lanePowerdownMask, laneActive, lanePolarityMask, indirectAddress;
    wire [7:0] indirectData, cfgWriteLanes, cfgAddr, cfgData;
    wire [15:0] laneEqualizerBoost;
    integer mismatches, compares, seed, cycles, pulses, i, r, n;
    logic [7:0] q, v, oldAddr, oldData, seenLanes, mirror [0:9];
    logic seenOther;
    localparam [149:0] ADR = {`SLC_ADDR_EQ_HIGH, `SLC_ADDR_EQ_LOW, `SLC_ADDR_POLARITY,
        `SLC_ADDR_IND_DATA, `SLC_ADDR_COMMIT_OTHER, `SLC_ADDR_COMMIT_LANES,
        `SLC_ADDR_IND_ADDR, `SLC_ADDR_CDR_RST, `SLC_ADDR_SYNC_PD, `SLC_ADDR_LANE_PD};
    localparam [79:0] RST = 80'hFFFF66000000000001EE;
    localparam [79:0] MSK = 80'hFFFFFFFF01FFFF0103FF;

    slc_lane_ctrl #(.LANES(8)) u_slc_lane_ctrl (.*);
    slc_host_model u_slc_host_model (.*);

    // clock at 100 MHz
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // commit pulse monitor and hang guard
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if ((|cfgWriteLanes) || cfgWriteOther) begin
            pulses <= pulses + 1;
            seenLanes <= cfgWriteLanes;
            seenOther <= cfgWriteOther;
        end
        if (cycles == 60000) begin
            mismatches = mismatches + 1;
            summarize;
        end
    end

    // ----------------------------------------------------------------
    // tasks
    // ----------------------------------------------------------------
    function [7:0] expAct(input [7:0] mask, input rel);
        expAct = ~mask & {8{rel}};
    endfunction

    task check(input string name, input [15:0] exp, input [15:0] got);
        compares = compares + 1;
        if (exp !== got) begin
            mismatches = mismatches + 1;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task wr(input integer idx, input [7:0] val);
        u_slc_host_model.frame(1'b0, ADR[15*idx +: 15], val, 24, q);
        mirror[idx] = val & MSK[8*idx +: 8]; // reserved bits read back zero
    endtask

    task rd(input integer idx);
        u_slc_host_model.frame(1'b1, ADR[15*idx +: 15], 8'h00, 24, q);
        check($sformatf("reg_%h", ADR[15*idx +: 15]), mirror[idx], q);
    endtask

    task checkPorts;
        check("lanePowerdownMask", mirror[0], lanePowerdownMask);
        check("laneActive", expAct(mirror[0], mirror[2][0]), laneActive);
        check("syncDriverAOff", mirror[1][1], syncDriverAOff);
        check("syncDriverBOff", mirror[1][0], syncDriverBOff);
        check("laneRxResetHold", !mirror[2][0], laneRxResetHold);
        check("indirectAddress", mirror[3], indirectAddress);
        check("indirectData", mirror[6], indirectData);
        check("lanePolarityMask", mirror[7], lanePolarityMask);
        check("laneEqualizerBoost", {mirror[9], mirror[8]}, laneEqualizerBoost);
    endtask

    task resetRun;
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        for (n = 0; n < 10; n = n + 1) mirror[n] = RST[8*n +: 8];
        repeat (4) @(posedge clk);
    endtask

    task summarize;
        $display("counts: mismatches %0d compares %0d", mismatches, compares);
        if (mismatches == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        mismatches = 0;
        compares = 0;
        cycles = 0;
        pulses = 0;
        seed = 62641;
        rst_n = 1'b0;
        resetRun;
        checkPorts;
        for (i = 0; i < 10; i = i + 1) rd(i);
        $display("test reset_values done");
        // unmapped place: write ignored, read returns zero
        u_slc_host_model.frame(1'b0, 15'h0202, 8'h5A, 24, q);
        u_slc_host_model.frame(1'b1, 15'h0202, 8'h00, 24, q);
        check("unmapped_read", `SLC_RD_UNMAPPED, q);
        checkPorts;
        // lanes stay held until release is written
        wr(0, $random(seed));
        checkPorts;
        wr(2, 8'h01);
        checkPorts;
        for (r = 0; r < 4; r = r + 1) begin
            wr(1, r);
            checkPorts;
        end
        wr(8, 8'hAA);
        wr(9, 8'h5F);
        checkPorts;
        $display("test lane_controls done");
        // staged address and data, then strobes
        wr(3, $random(seed));
        wr(6, $random(seed));
        r = pulses;
        v = $random(seed) | 8'h01;
        wr(4, v);
        check("commitCount", r + 1, pulses);
        check("cfgWriteLanes", v, seenLanes);
        check("cfgAddr", mirror[3], cfgAddr);
        check("cfgData", mirror[6], cfgData);
        r = pulses;
        wr(5, 8'h00);
        check("commitCount", r, pulses);
        wr(5, 8'h01);
        check("commitCount", r + 1, pulses);
        check("cfgWriteOther", 1'b1, seenOther);
        oldAddr = mirror[3];
        oldData = mirror[6];
        wr(3, ~oldAddr);
        wr(6, ~oldData);
        check("cfgAddr", oldAddr, cfgAddr);
        check("cfgData", oldData, cfgData);
        $display("test commit done");
        // aborted frame writes nothing
        u_slc_host_model.frame(1'b0, ADR[15*7 +: 15], 8'h00, 12, q);
        checkPorts;
        // random writes with readback
        for (r = 0; r < 2; r = r + 1) begin
            for (i = 0; i < 10; i = i + 1) begin
                v = $random(seed);
                if (i == 4) v = v | 8'h01;
                wr(i, v);
                rd(i);
            end
            checkPorts;
        end
        $display("test random_access done");
        resetRun;
        checkPorts;
        rd(7);
        $display("test second_reset done");
        summarize;
    end
endmodule // tb_slc_lane_ctrl
`default_nettype wire
